// [include/tog_pkg.sv]
// Purpose: constants and carriers for trigger output gating
// Assumes: one 25 MHz clock, measurement cycle made by a divider
// Notes: register offsets are byte addresses on a plain port
package tog_pkg;
  // Register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_COUNT = 8'h04;
  localparam logic [7:0] ADDR_CMD = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0c;
  localparam logic [7:0] ADDR_WORD = 8'h10;
  // Control field positions
  localparam int CB_TRIG = 0;
  localparam int CB_KIND = 1;
  localparam int CB_POL = 3;
  localparam int CB_TERM = 4;
  localparam int CB_ALL = 5;
  localparam int CB_NETX = 6;
  localparam int CB_IF = 7;
  localparam int CTRL_W = 9;
  // Command bits
  localparam int CMD_SW = 0;
  localparam int CMD_RST = 1;
  // Trigger kinds and output interfaces
  localparam logic [1:0] KIND_LEVEL = 2'h0;
  localparam logic [1:0] KIND_EDGE = 2'h1;
  localparam logic [1:0] KIND_SW = 2'h2;
  localparam logic [1:0] IF_NET = 2'h0;
  localparam logic [1:0] IF_FB = 2'h2;
  // Reset values and count codes
  localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;
  localparam logic [13:0] COUNT_RST = 14'h0001;
  localparam logic [13:0] COUNT_STOP = 14'h0000;
  localparam logic [13:0] COUNT_CONT = 14'h3fff;
  localparam logic [13:0] EVT_RST = 14'h3fff;
  // Timing
  localparam int CLK_NS = 40;
  localparam int CYCLE_NS = 10000;
  localparam logic [15:0] CYCLE_DIV = 16'(CYCLE_NS / CLK_NS);
  localparam int PIPE_DEPTH = 4;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } tog_bus_t;

  typedef struct packed {
    logic [31:0] data;
    logic [17:0] status;
  } tog_meas_t;

  typedef struct packed {
    logic valid;
    logic avgValid;
    logic wordValid;
    logic [31:0] data;
    logic [17:0] status;
    logic [31:0] word;
  } tog_out_t;

  typedef struct packed {
    logic [1:0] posS;
    logic [1:0] negS;
    logic lvlClk;
    logic lvlPrev;
    logic edgePend;
    logic swPend;
    logic rstPend;
    logic [15:0] div;
    logic tickQ;
    logic [CTRL_W-1:0] ctrl;
    logic [13:0] count;
    logic [13:0] remain;
    logic cont;
    logic [PIPE_DEPTH-1:0] pGate;
    logic [PIPE_DEPTH-1:0] pStart;
    logic [13:0] evt;
    logic [13:0] valNext;
    logic [13:0] valShow;
    tog_out_t out;
    logic [31:0] rdata;
  } tog_state_t;
endpackage

// [verilog/tog_trigger_gate.sv]
// Purpose: gate measurement output by level, edge or software trigger
// Assumes: measurement input is valid at each cycle tick
// Notes: output reacts four measurement cycles after the trigger
`timescale 1ns/1ps
`default_nettype none
module tog_trigger_gate (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Register port
  input wire tog_pkg::tog_bus_t bus,
  output logic [31:0] rdata,
  // Trigger pair
  input wire logic trigPos,
  input wire logic trigNeg,
  output logic termEn,
  // Measurement stream
  input wire tog_pkg::tog_meas_t meas,
  output logic cycleTick,
  output tog_pkg::tog_out_t out
);
  import tog_pkg::*;

  tog_state_t q;
  tog_state_t d;
  logic lvl;
  logic active;
  logic trigOn;
  logic [1:0] kind;
  logic [1:0] iface;
  logic startNow;
  logic gateNow;
  logic p3Gate;
  logic p3Start;
  logic passAll;
  logic mark;
  logic [13:0] vn;

  assign trigOn = q.ctrl[CB_TRIG];
  assign kind = q.ctrl[CB_KIND+:2];
  assign iface = q.ctrl[CB_IF+:2];
  assign lvl = q.posS[1] & ~q.negS[1];
  assign active = lvl == q.ctrl[CB_POL];
  assign p3Gate = q.pGate[PIPE_DEPTH-1];
  assign p3Start = q.pStart[PIPE_DEPTH-1];

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    startNow = 1'b0;
    gateNow = 1'b0;
    passAll = 1'b0;
    mark = 1'b0;
    vn = q.valNext;
    // Two flops before anything looks at the pins
    d.posS = {q.posS[0], trigPos};
    d.negS = {q.negS[0], trigNeg};
    d.lvlClk = lvl;
    // Divider gives the measurement cycle; rate never changes
    d.tickQ = q.div == CYCLE_DIV - 16'h0001;
    d.div = d.tickQ ? 16'h0000 : q.div + 16'h0001;
    if (q.tickQ) begin
      d.edgePend = 1'b0;
      d.swPend = 1'b0;
    end
    // Short edges are latched at clock rate; pending edge wins over clear
    if (lvl != q.lvlClk && active) begin
      d.edgePend = 1'b1;
    end
    case (kind)
      KIND_LEVEL: begin
        startNow = trigOn & active & ~q.lvlPrev;
        gateNow = active;
      end
      // A zero count refuses the start, so no event is counted either
      KIND_EDGE: begin
        startNow = trigOn & q.edgePend & (q.count != COUNT_STOP);
      end
      KIND_SW: begin
        startNow = trigOn & q.swPend & (q.count != COUNT_STOP);
      end
      default: begin
        startNow = 1'b0;
      end
    endcase
    if (kind == KIND_EDGE || kind == KIND_SW) begin
      gateNow = (startNow || q.cont || q.remain != 14'h0000) &&
                q.count != COUNT_STOP;
    end
    ////////////////////////////////////////////////////////////////////
    if (q.tickQ) begin
      d.lvlPrev = active;
      if (kind == KIND_EDGE || kind == KIND_SW) begin
        if (startNow) begin
          d.cont = q.count == COUNT_CONT;
          d.remain = d.cont ? 14'h0000 : q.count - 14'h0001;
        end else if (q.remain != 14'h0000) begin
          d.remain = q.remain - 14'h0001;
        end
        if (q.count == COUNT_STOP) begin
          d.cont = 1'b0;
          d.remain = 14'h0000;
        end
      end
      // Fixed four-stage delay keeps reaction latency constant
      d.pGate = {q.pGate[PIPE_DEPTH-2:0], gateNow & trigOn};
      d.pStart = {q.pStart[PIPE_DEPTH-2:0], startNow};
      if (p3Start) begin
        d.evt = q.rstPend ? 14'h0000 : q.evt + 14'h0001;
        d.rstPend = 1'b0;
        vn = 14'h0000;
      end
      if (p3Gate) begin
        d.valShow = vn;
        vn = vn + 14'h0001;
      end
      d.valNext = vn;
      // Fieldbus cannot carry the all-values marking
      passAll = ~trigOn || kind == 2'h3 ||
                (q.ctrl[CB_ALL] && iface != IF_FB);
      mark = trigOn & p3Gate;
      d.out.valid = p3Gate | passAll;
      d.out.avgValid = mark | ~trigOn;
      d.out.data = meas.data;
      d.out.status = {meas.status[17:16], mark, meas.status[14:0]};
      d.out.word = {mark, 1'b0, d.evt, 2'b00, d.valShow};
      d.out.wordValid = d.out.valid && q.ctrl[CB_NETX] && iface == IF_NET;
    end else begin
      d.out.valid = 1'b0;
      d.out.avgValid = 1'b0;
      d.out.wordValid = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////
    if (bus.wr) begin
      case (bus.addr)
        ADDR_CTRL: begin
          d.ctrl = bus.wdata[CTRL_W-1:0];
        end
        ADDR_COUNT: begin
          d.count = bus.wdata[13:0];
        end
        ADDR_CMD: begin
          if (bus.wdata[CMD_SW]) begin
            d.swPend = 1'b1;
          end
          if (bus.wdata[CMD_RST]) begin
            d.rstPend = 1'b1;
          end
        end
        default: begin
          d.ctrl = d.ctrl;
        end
      endcase
    end
    d.rdata = 32'h0000_0000;
    if (bus.rd) begin
      case (bus.addr)
        ADDR_CTRL: d.rdata = 32'(q.ctrl);
        ADDR_COUNT: d.rdata = 32'(q.count);
        ADDR_STAT: d.rdata = 32'({q.rstPend, lvl, q.cont, q.remain != 14'h0000});
        ADDR_WORD: d.rdata = q.out.word;
        default: d.rdata = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
      q.ctrl <= CTRL_RST;
      q.count <= COUNT_RST;
      // Event count sits one below zero so the first event reads 0
      q.evt <= EVT_RST;
    end else begin
      q <= d;
    end
  end

  assign rdata = q.rdata;
  assign termEn = q.ctrl[CB_TERM];
  assign cycleTick = q.tickQ;
  assign out = q.out;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_term_bit: assert property (
    bus.wr && bus.addr == ADDR_CTRL |=> termEn == $past(bus.wdata[CB_TERM]))
    else $error("termination bit not applied");
  a_sync_free: assert property (
    q.tickQ && !trigOn |=> out.valid && !out.status[15])
    else $error("sync mode output gated or marked");
  a_level_out: assert property (
    q.tickQ && trigOn && kind == KIND_LEVEL && !q.ctrl[CB_ALL]
    |=> out.valid == $past(p3Gate))
    else $error("level gating mismatch");
  a_cont_sel: assert property (
    q.tickQ && startNow && kind != KIND_LEVEL && q.count == COUNT_CONT |=> q.cont)
    else $error("continuous code not decoded");
  a_zero_stop: assert property (
    q.tickQ && q.count == COUNT_STOP && (kind == KIND_EDGE || kind == KIND_SW)
    |=> !q.cont && q.remain == 14'h0000)
    else $error("zero count did not stop");
  a_evt_inc: assert property (
    q.tickQ && p3Start && !q.rstPend |=> q.evt == $past(q.evt) + 14'h0001)
    else $error("event count not incremented");
  a_evt_clear: assert property (
    q.tickQ && p3Start && q.rstPend |=> q.evt == 14'h0000 && !q.rstPend)
    else $error("counter reset not applied at trigger");
  a_val_clear: assert property (
    q.tickQ && p3Start && p3Gate |=> out.word[13:0] == 14'h0000)
    else $error("value count not cleared");
  a_mark_bit: assert property (
    out.valid |-> out.status[15] == out.word[31])
    else $error("marker and status bit differ");
  a_fb_gated: assert property (
    q.tickQ && trigOn && kind != 2'h3 && iface == IF_FB |=> out.valid == $past(p3Gate))
    else $error("fieldbus got ungated values");
  a_net_only: assert property (
    out.wordValid |-> $past(iface) == IF_NET && $past(q.ctrl[CB_NETX]))
    else $error("counter word off network stream");
  a_read_once: assert property (
    !$past(bus.rd) |-> rdata == 32'h0000_0000)
    else $error("read data outside its cycle");

  ////////////////////////////////////////////////////////////////////////
  // Cycle timing and output pulses
  a_tick_rate: assert property (
    q.div == CYCLE_DIV - 16'h0001 |=> q.tickQ && q.div == 16'h0000)
    else $error("measurement cycle divider off rate");
  a_tick_pulse: assert property (
    q.tickQ |=> !q.tickQ)
    else $error("cycle tick longer than one clock");
  a_valid_slot: assert property (
    out.valid |-> $past(q.tickQ))
    else $error("output outside a measurement cycle");
  a_valid_pulse: assert property (
    out.valid |=> !out.valid)
    else $error("output strobe longer than one clock");
  a_delay_line: assert property (
    q.tickQ |=> q.pGate[PIPE_DEPTH-1:1] == $past(q.pGate[PIPE_DEPTH-2:0]))
    else $error("trigger delay line skipped a stage");
  a_word_net: assert property (
    out.wordValid |-> out.valid)
    else $error("counter word without a value");
  a_avg_mark: assert property (
    q.tickQ && trigOn |=> out.avgValid == out.status[15])
    else $error("untriggered value fed to averaging");
  a_val_step: assert property (
    q.tickQ && p3Gate && !p3Start |=> out.word[13:0] == $past(q.valNext))
    else $error("value count did not advance");

  // Trigger capture; a missed latch would drop a short edge silently
  a_pin_sync: assert property (
    q.posS[1] == $past(q.posS[0]) && q.negS[1] == $past(q.negS[0]))
    else $error("trigger pins skipped a sync stage");
  a_edge_latch: assert property (
    lvl != q.lvlClk && active |=> q.edgePend)
    else $error("configured edge not latched");
  a_sw_latch: assert property (
    bus.wr && bus.addr == ADDR_CMD && bus.wdata[CMD_SW] |=> q.swPend)
    else $error("software trigger not latched");
  a_rst_latch: assert property (
    bus.wr && bus.addr == ADDR_CMD && bus.wdata[CMD_RST] |=> q.rstPend)
    else $error("counter reset not held until trigger");
  a_level_gate: assert property (
    q.tickQ && trigOn && kind == KIND_LEVEL |=> q.pGate[0] == $past(active))
    else $error("level not sampled into the delay line");
  a_stop_gate: assert property (
    q.tickQ && (kind == KIND_EDGE || kind == KIND_SW) && q.count == COUNT_STOP
    |=> !q.pGate[0] && !q.pStart[0])
    else $error("zero count still started output");
endmodule
`default_nettype wire

// [dv/tog_trig_src.sv]
// Purpose: external trigger source with a differential line driver
// Assumes: both lines modelled as digital, always complementary
// Notes: callers keep every phase at 250 clocks or more
`timescale 1ns/1ps
`default_nettype none
module tog_trig_src (
  // Clock
  input wire logic ref_clk,
  // Trigger pair
  output logic trigPos,
  output logic trigNeg
);
  initial begin
    trigPos = 1'b0;
    trigNeg = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Drives one level for n clocks; a driver never leaves the pair floating
  task automatic drive(input logic lvl, input int n);
    @(posedge ref_clk);
    trigPos <= lvl;
    trigNeg <= ~lvl;
    repeat (n) @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

// [dv/tog_trigger_gate_test.sv]
// Purpose: self-checking bench for trigger output gating
// Assumes: 25 MHz clock, one measurement cycle every CYCLE_DIV clocks
// Notes: output is recorded per valid pulse and judged per scenario
`timescale 1ns/1ps
`default_nettype none
module tog_trigger_gate_test;
  import tog_pkg::*;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  tog_bus_t bus = '0;
  tog_meas_t meas = '0;
  logic [31:0] rdata;
  logic trigPos, trigNeg, termEn, cycleTick;
  tog_out_t out;
  int errCount = 0;
  int cmpCount = 0;
  int cycles = 0;
  logic [31:0] words[$];
  logic [34:0] marks[$];
  always #20 ref_clk = ~ref_clk;
  tog_trigger_gate uut (.ref_clk(ref_clk), .rstn(rstn), .bus(bus), .rdata(rdata),
    .trigPos(trigPos), .trigNeg(trigNeg), .termEn(termEn), .meas(meas),
    .cycleTick(cycleTick), .out(out));
  tog_trig_src src (.ref_clk(ref_clk), .trigPos(trigPos), .trigNeg(trigNeg));
  ////////////////////////////////////////////////////////////////////////////
  // Fresh value each cycle; recorder and hang guard
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycleTick === 1'b1) begin
      meas.data <= meas.data + 32'h0000_0001;
    end
    if (out.valid === 1'b1) begin
      words.push_back(out.word);
      marks.push_back({out.wordValid, out.avgValid, out.status[15], out.data});
    end
    if (cycles == 40000) begin
      errCount++;
      endSim();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmpCount++;
    if (got !== exp) begin
      errCount++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    bus.wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the read edge
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic ticks(input int n);
    repeat (n * int'(CYCLE_DIV)) @(posedge ref_clk);
  endtask
  function automatic logic [31:0] mode(input logic [1:0] k);
    mode = '0;
    mode[CB_TRIG] = 1'b1;
    mode[CB_KIND +: 2] = k;
    mode[CB_POL] = 1'b1;
    mode[CB_NETX] = 1'b1;
  endfunction
  // n values, marker m; triggered words count 0.. within event e
  task automatic checkRun(input int n, input logic [13:0] e, input logic m);
    chk(32'(words.size()), 32'(n));
    for (int i = 0; i < words.size(); i++) begin
      chk({29'h0000_0000, marks[i][34:32]}, {29'h0000_0000, m, 1'b1, m});
      if (i > 0) begin
        chk(marks[i][31:0], marks[i-1][31:0] + 32'h0000_0001);
      end
      if (m) begin
        chk(words[i], {1'b1, 1'b0, e, 2'b00, 14'(i)});
      end
    end
    words.delete();
    marks.delete();
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic testRegs();
    rd(ADDR_CTRL, 32'(CTRL_RST));
    rd(ADDR_COUNT, 32'(COUNT_RST));
    rd(8'h20, 32'h0000_0000);
    chk({31'h0000_0000, termEn}, 32'h0000_0000);
    wr(ADDR_CTRL, 32'h0000_0010);
    #1;
    chk({31'h0000_0000, termEn}, 32'h0000_0001);
  endtask
  // Synchronization mode passes every value unmarked
  task automatic testSync();
    ticks(1);
    words.delete();
    marks.delete();
    ticks(4);
    checkRun(4, 14'h0000, 1'b0);
  endtask
  // Nothing before the fourth cycle; events count from zero
  task automatic testEdge();
    wr(ADDR_COUNT, 32'h0000_0003);
    wr(ADDR_CTRL, mode(KIND_EDGE));
    ticks(2);
    for (int e = 0; e < 2; e++) begin
      words.delete();
      marks.delete();
      src.drive(1'b1, 500);
      ticks(1);
      chk(32'(words.size()), 32'h0000_0000);
      src.drive(1'b0, 1750);
      checkRun(3, 14'(e), 1'b1);
      rd(ADDR_WORD, {2'b00, 14'(e), 2'b00, 14'h0002});
    end
  endtask
  // Counter reset lands at the next start; a zero count gives nothing
  task automatic testSoft();
    wr(ADDR_CTRL, mode(KIND_SW));
    wr(ADDR_COUNT, 32'h0000_0002);
    wr(ADDR_CMD, 32'h0000_0002);
    rd(ADDR_STAT, 32'h0000_0008);
    ticks(2);
    words.delete();
    marks.delete();
    wr(ADDR_CMD, 32'h0000_0001);
    ticks(9);
    checkRun(2, 14'h0000, 1'b1);
    wr(ADDR_COUNT, 32'h0000_0000);
    wr(ADDR_CMD, 32'h0000_0001);
    ticks(9);
    checkRun(0, 14'h0000, 1'b1);
  endtask
  // Five cycles of active level give five values
  task automatic testLevel();
    wr(ADDR_CTRL, mode(KIND_LEVEL));
    ticks(2);
    words.delete();
    marks.delete();
    src.drive(1'b1, 5 * int'(CYCLE_DIV));
    src.drive(1'b0, 10 * int'(CYCLE_DIV));
    checkRun(5, 14'h0001, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic endSim();
    $display("Counts: %0d mismatches in %0d compares", errCount, cmpCount);
    if (errCount == 0 && cmpCount > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    testRegs();
    testSync();
    testEdge();
    testSoft();
    testLevel();
    endSim();
  end
endmodule
`default_nettype wire
